// File: lcct_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for the external rollover pin
`timescale 1ns/1ps
module lcct_edge_sync (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      rise_pulse
);

    logic meta_q;
    logic sync_q;
    logic last_q;
    logic rise_q;

    // Synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    // Edge detect on the settled level
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            last_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            last_q <= sync_q;
            rise_q <= sync_q & ~last_q;
        end
    end

    assign rise_pulse = rise_q;

endmodule : lcct_edge_sync

// File: lcct_link_control.sv
// Link control register with APB slave and the cycle timer offset it steers
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module lcct_link_control
    import lcct_pkg::*;
#(
    parameter int unsigned NUM_IR_CTX = 4
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_AW-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Cycle timer
    input  wire logic                  offset_tick,
    input  wire logic                  external_rollover_input,
    input  wire logic                  overlong_period_event,
    input  wire lcct_cyc_start_t       rx_cycle_start,
    output logic [OFFSET_W-1:0]        cycle_offset,
    output logic                       cycle_rollover,
    output logic                       cycle_start_req,
    // Receiver gating
    input  wire logic                  phy_pkt_rcvd,
    input  wire logic                  self_id_rcvd,
    input  wire logic                  async_receive_ctx_enabled,
    output logic                       phy_pkt_accept,
    output logic                       self_id_accept,
    // Isochronous receive match sync filter bits
    input  wire logic [NUM_IR_CTX-1:0] sync_filter_sw,
    output logic [NUM_IR_CTX-1:0]      per_context_sync_filter,
    // Control fields for the rest of the link
    output lcct_ctl_t                  link_ctl
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_mask

    // Control fields packed into the register word
    function automatic logic [31:0] ctl_word(input lcct_ctl_t c);
        logic [31:0] w;
        w = LC_RESET_VALUE;
        w[LC_SRC_BIT]    = c.rollover_source_select;
        w[LC_MASTER_BIT] = c.root_start_packet_gen;
        w[LC_EN_BIT]     = c.offset_count_enable;
        w[LC_PHY_BIT]    = c.accept_phy_packets;
        w[LC_SID_BIT]    = c.accept_self_id_packets;
        w[LC_LOCK_BIT]   = c.sync_filter_force_lock;
        return w;
    endfunction : ctl_word

    // Address is one of the mapped registers
    function automatic logic addr_hit(input logic [APB_AW-1:0] a);
        return (a == LC_SET_ADDR) || (a == LC_CLR_ADDR) || (a == OFFSET_STAT_ADDR);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // State

    lcct_ctl_t           ctl_q;
    logic                pready_q;
    logic [31:0]         prdata_q;
    logic                pslverr_q;
    logic [OFFSET_W-1:0] offset_q;
    logic                rollover_q;
    logic                start_req_q;
    logic                phy_acc_q;
    logic                sid_acc_q;
    logic [NUM_IR_CTX-1:0] sync_filter_q;
    logic                ext_edge;
    logic                bus_setup;
    logic                bus_done;
    logic                wr_set;
    logic                wr_clr;
    logic [31:0]         wr_bits;
    logic                rx_load;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, answer prepared in the setup cycle

    // Bus phase decode
    assign bus_setup = psel & ~penable;
    assign bus_done  = psel & penable & pready_q;
    assign wr_set    = bus_done & pwrite & (paddr == LC_SET_ADDR);
    assign wr_clr    = bus_done & pwrite & (paddr == LC_CLR_ADDR);
    assign wr_bits   = pwdata & strb_mask(pstrb) & LC_WRITABLE_MASK;

    // Ready raised for the access phase only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= bus_setup;
        end
    end

    // Read data and error captured at setup
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (bus_setup) begin
            pslverr_q <= ~addr_hit(paddr);
            if (pwrite) begin
                prdata_q <= 32'h0000_0000;
            end else if ((paddr == LC_SET_ADDR) || (paddr == LC_CLR_ADDR)) begin
                prdata_q <= ctl_word(ctl_q);
            end else if (paddr == OFFSET_STAT_ADDR) begin
                prdata_q <= {20'h0_0000, offset_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link control register

    // Ordinary set/clear fields
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_q.rollover_source_select <= 1'b0;
            ctl_q.offset_count_enable    <= 1'b0;
            ctl_q.accept_phy_packets     <= 1'b0;
            ctl_q.accept_self_id_packets <= 1'b0;
        end else if (wr_set) begin
            ctl_q.rollover_source_select <= ctl_q.rollover_source_select | wr_bits[LC_SRC_BIT];
            ctl_q.offset_count_enable    <= ctl_q.offset_count_enable | wr_bits[LC_EN_BIT];
            ctl_q.accept_phy_packets     <= ctl_q.accept_phy_packets | wr_bits[LC_PHY_BIT];
            ctl_q.accept_self_id_packets <= ctl_q.accept_self_id_packets | wr_bits[LC_SID_BIT];
        end else if (wr_clr) begin
            ctl_q.rollover_source_select <= ctl_q.rollover_source_select & ~wr_bits[LC_SRC_BIT];
            ctl_q.offset_count_enable    <= ctl_q.offset_count_enable & ~wr_bits[LC_EN_BIT];
            ctl_q.accept_phy_packets     <= ctl_q.accept_phy_packets & ~wr_bits[LC_PHY_BIT];
            ctl_q.accept_self_id_packets <= ctl_q.accept_self_id_packets & ~wr_bits[LC_SID_BIT];
        end
    end

    // Master bit; the overlong event beats any software set
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_q.root_start_packet_gen <= 1'b0;
        end else if (overlong_period_event) begin
            ctl_q.root_start_packet_gen <= 1'b0;
        end else if (wr_set && wr_bits[LC_MASTER_BIT]) begin
            ctl_q.root_start_packet_gen <= 1'b1;
        end else if (wr_clr && wr_bits[LC_MASTER_BIT]) begin
            ctl_q.root_start_packet_gen <= 1'b0;
        end
    end

    // Lock bit: set only, cleared by global reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_q.sync_filter_force_lock <= 1'b0;
        end else if (wr_set && wr_bits[LC_LOCK_BIT]) begin
            ctl_q.sync_filter_force_lock <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle timer offset

    // External rollover pin, synchronised
    lcct_edge_sync u_ext_sync (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .async_in   (external_rollover_input),
        .rise_pulse (ext_edge)
    );

    // Resync from received cycle start when not root
    assign rx_load = rx_cycle_start.valid & ~ctl_q.root_start_packet_gen;

    // Offset counter and rollover pulse
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            offset_q   <= OFFSET_RESET;
            rollover_q <= 1'b0;
        end else begin
            rollover_q <= 1'b0;
            if (!ctl_q.offset_count_enable) begin
                offset_q <= offset_q;
            end else if (rx_load) begin
                offset_q <= rx_cycle_start.offset;
            end else if (ctl_q.rollover_source_select) begin
                if (ext_edge) begin
                    offset_q   <= OFFSET_RESET;
                    rollover_q <= 1'b1;
                end else if (offset_tick) begin
                    offset_q <= offset_q + 12'h001;
                end
            end else if (offset_tick) begin
                if (offset_q >= OFFSET_MAX) begin
                    offset_q   <= OFFSET_RESET;
                    rollover_q <= 1'b1;
                end else begin
                    offset_q <= offset_q + 12'h001;
                end
            end
        end
    end

    // Cycle start request while root
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            start_req_q <= 1'b0;
        end else begin
            start_req_q <= ctl_q.offset_count_enable & ~rx_load & ctl_q.root_start_packet_gen
                         & (ctl_q.rollover_source_select ? ext_edge
                            : (offset_tick & (offset_q >= OFFSET_MAX)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver gating and sync filter forcing

    // PHY and self-ID packet acceptance
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phy_acc_q <= 1'b0;
            sid_acc_q <= 1'b0;
        end else begin
            phy_acc_q <= phy_pkt_rcvd & ctl_q.accept_phy_packets
                       & async_receive_ctx_enabled;
            sid_acc_q <= self_id_rcvd & ctl_q.accept_self_id_packets;
        end
    end

    // Per-context filter bits, forced high under lock
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_filter_q <= '0;
        end else if (ctl_q.sync_filter_force_lock) begin
            sync_filter_q <= '1;
        end else begin
            sync_filter_q <= sync_filter_sw;
        end
    end

    // Outputs, all from flops
    assign pready                  = pready_q;
    assign prdata                  = prdata_q;
    assign pslverr                 = pslverr_q;
    assign cycle_offset            = offset_q;
    assign cycle_rollover          = rollover_q;
    assign cycle_start_req         = start_req_q;
    assign phy_pkt_accept          = phy_acc_q;
    assign self_id_accept          = sid_acc_q;
    assign per_context_sync_filter = sync_filter_q;
    assign link_ctl                = ctl_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_reserved_zero;
        pready_q && !pwrite && !pslverr_q && (paddr != OFFSET_STAT_ADDR)
            |-> ((prdata_q & ~LC_WRITABLE_MASK) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved link control bits read nonzero");
    property p_set_enable;
        wr_set && pwdata[LC_EN_BIT] && pstrb[2] |=> ctl_q.offset_count_enable;
    endproperty
    a_set_enable: assert property (p_set_enable)
        else $error("set address write did not set enable");
    property p_clear_enable;
        wr_clr && pwdata[LC_EN_BIT] && pstrb[2] |=> !ctl_q.offset_count_enable;
    endproperty
    a_clear_enable: assert property (p_clear_enable)
        else $error("clear address write did not clear enable");
    property p_internal_roll;
        ctl_q.offset_count_enable && !ctl_q.rollover_source_select && !rx_load
            && offset_tick && (offset_q == OFFSET_MAX)
            |=> (offset_q == OFFSET_RESET) && rollover_q;
    endproperty
    a_internal_roll: assert property (p_internal_roll)
        else $error("internal rollover missed at terminal offset");
    property p_ext_roll;
        ctl_q.offset_count_enable && ctl_q.rollover_source_select && !rx_load && ext_edge
            |=> (offset_q == OFFSET_RESET) && rollover_q;
    endproperty
    a_ext_roll: assert property (p_ext_roll)
        else $error("external rollover edge ignored");
    property p_no_count_roll;
        ctl_q.rollover_source_select && !ext_edge |=> !rollover_q;
    endproperty
    a_no_count_roll: assert property (p_no_count_roll)
        else $error("rollover without external edge");
    property p_master_clear;
        overlong_period_event |=> !ctl_q.root_start_packet_gen;
    endproperty
    a_master_clear: assert property (p_master_clear)
        else $error("master bit survived overlong event");
    property p_master_blocked;
        overlong_period_event && wr_set && pwdata[LC_MASTER_BIT] && pstrb[2]
            |=> !ctl_q.root_start_packet_gen;
    endproperty
    a_master_blocked: assert property (p_master_blocked)
        else $error("master bit set while overlong event high");
    property p_hold;
        !ctl_q.offset_count_enable |=> $stable(offset_q) && !rollover_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("offset moved while disabled");
    property p_advance;
        ctl_q.offset_count_enable && !ctl_q.rollover_source_select && !rx_load
            && offset_tick && (offset_q < OFFSET_MAX)
            |=> offset_q == $past(offset_q) + 12'h001;
    endproperty
    a_advance: assert property (p_advance)
        else $error("offset did not advance on tick");
    property p_start;
        rollover_q |-> (cycle_start_req == $past(ctl_q.root_start_packet_gen));
    endproperty
    a_start: assert property (p_start)
        else $error("cycle start request does not follow master bit");

    property p_resync;
        ctl_q.offset_count_enable && rx_load |=> offset_q == $past(rx_cycle_start.offset);
    endproperty
    a_resync: assert property (p_resync)
        else $error("received cycle start did not load offset");

    property p_lock_sticky;
        ctl_q.sync_filter_force_lock |=> ctl_q.sync_filter_force_lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared without reset");

    property p_force;
        ctl_q.sync_filter_force_lock |=> (&per_context_sync_filter);
    endproperty
    a_force: assert property (p_force)
        else $error("sync filter bits not forced under lock");

    property p_phy_gate;
        phy_pkt_rcvd && !(ctl_q.accept_phy_packets && async_receive_ctx_enabled)
            |=> !phy_pkt_accept;
    endproperty
    a_phy_gate: assert property (p_phy_gate)
        else $error("PHY packet accepted while gated off");

    property p_self_id;
        self_id_rcvd |=> (self_id_accept == $past(ctl_q.accept_self_id_packets));
    endproperty
    a_self_id: assert property (p_self_id)
        else $error("self-ID acceptance does not follow its bit");

endmodule : lcct_link_control

// File: lcct_pkg.sv
// Package: link control register map, field layout and cycle timer constants
package lcct_pkg;

    // APB map
    localparam int unsigned APB_AW           = 12;
    localparam logic [11:0] LC_SET_ADDR      = 12'h0e0;
    localparam logic [11:0] LC_CLR_ADDR      = 12'h0e4;
    localparam logic [11:0] OFFSET_STAT_ADDR = 12'h0f0;

    // Field positions in the link control word
    localparam int unsigned LC_SRC_BIT    = 22;
    localparam int unsigned LC_MASTER_BIT = 21;
    localparam int unsigned LC_EN_BIT     = 20;
    localparam int unsigned LC_PHY_BIT    = 10;
    localparam int unsigned LC_SID_BIT    = 9;
    localparam int unsigned LC_LOCK_BIT   = 6;
    localparam logic [31:0] LC_WRITABLE_MASK = 32'h0070_0640;
    localparam logic [31:0] LC_RESET_VALUE   = 32'h0000_0000;

    // Cycle timer: 125 us period at a 24.576 MHz tick
    localparam int unsigned TICK_FREQ_KHZ   = 24576;
    localparam int unsigned CYCLE_PERIOD_US = 125;
    localparam int unsigned TICKS_PER_CYCLE = CYCLE_PERIOD_US * TICK_FREQ_KHZ / 1000;
    localparam int unsigned OFFSET_W        = 12;
    localparam logic [11:0] OFFSET_MAX      = 12'(TICKS_PER_CYCLE - 1);
    localparam logic [11:0] OFFSET_RESET    = 12'h000;

    // Control fields as seen by the rest of the link
    typedef struct packed {
        logic rollover_source_select;
        logic root_start_packet_gen;
        logic offset_count_enable;
        logic accept_phy_packets;
        logic accept_self_id_packets;
        logic sync_filter_force_lock;
    } lcct_ctl_t;

    // Received cycle start packet
    typedef struct packed {
        logic        valid;
        logic [11:0] offset;
    } lcct_cyc_start_t;

endpackage : lcct_pkg

// File: lcct_testbench.sv
// Testbench for the link control register and its cycle timer
`timescale 1ns/1ps
module testbench;
    import lcct_pkg::*;

    logic                  ref_clk = 1'b0;
    logic                  reset = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [APB_AW-1:0]     paddr = '0;
    logic [31:0]           pwdata = '0;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  ext_in = 1'b0;
    logic                  tick = 1'b1;
    logic                  overlong = 1'b0;
    lcct_cyc_start_t       rx_cs = '0;
    logic [OFFSET_W-1:0]   offset;
    logic                  roll;
    logic                  start_req;
    logic                  phy_rx = 1'b0;
    logic                  sid_rx = 1'b0;
    logic                  ctx_en = 1'b0;
    logic                  phy_acc;
    logic                  sid_acc;
    logic [3:0]            filt;
    lcct_ctl_t             ctl;
    logic [31:0]           rd;
    logic                  er;
    logic [11:0]           hold;
    int                    n;
    int                    error_cnt = 0;
    int                    checks = 0;

    lcct_link_control #(.NUM_IR_CTX(4)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .offset_tick(tick), .external_rollover_input(ext_in),
        .overlong_period_event(overlong), .rx_cycle_start(rx_cs), .cycle_offset(offset),
        .cycle_rollover(roll), .cycle_start_req(start_req), .phy_pkt_rcvd(phy_rx),
        .self_id_rcvd(sid_rx), .async_receive_ctx_enabled(ctx_en), .phy_pkt_accept(phy_acc),
        .self_id_accept(sid_acc), .sync_filter_sw(4'h5), .per_context_sync_filter(filt),
        .link_ctl(ctl)
    );

    // Clock, 50 ns period
    always #25 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and run end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask : apb

    // Bounded wait for a rollover pulse, edges counted
    task automatic wait_roll(input int lim);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (roll !== 1'b1 && n < lim);
        if (roll !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_roll

    // Received packet pulses and the accept pulses one cycle later
    task automatic rcv(input logic ep, input logic es);
        @(posedge ref_clk);
        phy_rx <= 1'b1;
        sid_rx <= 1'b1;
        @(posedge ref_clk);
        phy_rx <= 1'b0;
        sid_rx <= 1'b0;
        @(posedge ref_clk);
        chk("phy accept", {31'h0, phy_acc}, {31'h0, ep});
        chk("self id accept", {31'h0, sid_acc}, {31'h0, es});
    endtask : rcv

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("reset value", rd, LC_RESET_VALUE);
        apb(1'b1, LC_SET_ADDR, 32'hffff_ffff);
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("set all", rd, 32'h0070_0640);
        chk("control fields", {26'h0, ctl}, 32'h0000_003f);
        apb(1'b0, LC_CLR_ADDR, 32'h0);
        chk("clear port read", rd, 32'h0070_0640);
        apb(1'b1, LC_CLR_ADDR, 32'hffff_ffff);
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("clear all", rd, 32'h0000_0040);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        chk("locked filter", {28'h0, filt}, 32'hf);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("lock after reset", rd, 32'h0);
        chk("free filter", {28'h0, filt}, 32'h5);
        $display("test registers complete");
        // Overlong event against the master bit
        overlong <= 1'b1;
        apb(1'b1, LC_SET_ADDR, 32'h0020_0000);
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("master blocked", rd, 32'h0);
        overlong <= 1'b0;
        apb(1'b1, LC_SET_ADDR, 32'h0020_0000);
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("master set", rd, 32'h0020_0000);
        overlong <= 1'b1;
        repeat (2) @(posedge ref_clk);
        apb(1'b0, LC_SET_ADDR, 32'h0);
        chk("master cleared", rd, 32'h0);
        overlong <= 1'b0;
        $display("test overlong complete");
        // Internal rollover as root, then counting stopped
        apb(1'b1, LC_SET_ADDR, 32'h0030_0000);
        wait_roll(4000);
        wait_roll(4000);
        chk("cycle period", 32'(n), 32'd3072);
        chk("offset at roll", {20'h0, offset}, 32'h0);
        chk("start request", {31'h0, start_req}, 32'h1);
        // Ticks withheld: offset must not move
        tick <= 1'b0;
        @(posedge ref_clk);
        hold = offset;
        repeat (5) @(posedge ref_clk);
        chk("offset without tick", {20'h0, offset}, {20'h0, hold});
        tick <= 1'b1;
        apb(1'b1, LC_CLR_ADDR, 32'h0010_0000);
        @(posedge ref_clk);
        hold = offset;
        repeat (10) @(posedge ref_clk);
        chk("offset held", {20'h0, offset}, {20'h0, hold});
        apb(1'b0, OFFSET_STAT_ADDR, 32'h0);
        chk("offset status", rd, {20'h0, hold});
        $display("test internal complete");
        // Resync from a received start, then external rollover
        apb(1'b1, LC_CLR_ADDR, 32'h0020_0000);
        apb(1'b1, LC_SET_ADDR, 32'h0050_0000);
        @(posedge ref_clk);
        rx_cs <= '{valid: 1'b1, offset: 12'h100};
        @(posedge ref_clk);
        rx_cs <= '0;
        @(posedge ref_clk);
        chk("resync offset", {20'h0, offset}, 32'h100);
        ext_in <= 1'b1;
        wait_roll(8);
        chk("external roll", {20'h0, offset}, 32'h0);
        chk("no start as slave", {31'h0, start_req}, 32'h0);
        ext_in <= 1'b0;
        $display("test external complete");
        // Receiver gating
        ctx_en <= 1'b1;
        apb(1'b1, LC_SET_ADDR, 32'h0000_0400);
        rcv(1'b1, 1'b0);
        apb(1'b1, LC_CLR_ADDR, 32'h0000_0400);
        apb(1'b1, LC_SET_ADDR, 32'h0000_0200);
        rcv(1'b0, 1'b1);
        apb(1'b1, LC_SET_ADDR, 32'h0000_0400);
        ctx_en <= 1'b0;
        rcv(1'b0, 1'b1);
        $display("test receive complete");
        wrap_up();
    end

endmodule : testbench
